//--- hw/ssu_consts.svh
// constants of the serial shift unit: reset values, counter figures and timing
`ifndef SSU_CONSTS_SVH
`define SSU_CONSTS_SVH

// =====================================================================
// reset values
`define SSU_SHIFT_RST        8'h00
`define SSU_CNT_RST          4'h0
`define SSU_SYNC_RST         4'h3

// =====================================================================
// counter figures
`define SSU_CNT_MAX          4'hF
`define SSU_CNT_ONE          4'h1
`define SSU_ACK_PRESET       4'hE
`define SSU_MSB_POS          7

// =====================================================================
// timing: sda delay in front of the start detector, link clock period
`define SSU_SDA_DLY_MIN_NS   50
`define SSU_SDA_DLY_MAX_NS   300
`define SSU_LINK_PERIOD_NS   160
`define SSU_SDA_DLY_CYC      (`SSU_SDA_DLY_MAX_NS / `SSU_LINK_PERIOD_NS)

// =====================================================================
// system clock and the least serial clock period in system cycles
`define SSU_SYS_PERIOD_NS    5
`define SSU_SCL_MIN_CYC      4

// =====================================================================
// synchroniser input positions in the system domain
`define SSU_IN_SCL           0
`define SSU_IN_SDA           1
`define SSU_IN_DI            2
`define SSU_IN_START         3
`define SSU_IN_NUM           4

`endif

//--- hw/ssu_pkg.sv
// types of the serial shift unit: wire modes, clock sources and control bundle
package ssu_pkg;

   // ==================================================================
   // wire mode selection
   typedef enum logic [1:0] {
      SSU_WM_OFF     = 2'b00,
      SSU_WM_THREE   = 2'b01,
      SSU_WM_TWO     = 2'b10,
      SSU_WM_TWO_OVH = 2'b11
   } ssu_wire_mode_t;

   // ==================================================================
   // clock source: external_clock_select, external_edge_select
   typedef enum logic [1:0] {
      SSU_CS_SOFT    = 2'b00,
      SSU_CS_TIMER   = 2'b01,
      SSU_CS_EXT_POS = 2'b10,
      SSU_CS_EXT_NEG = 2'b11
   } ssu_clk_src_t;

   // ==================================================================
   // control bundle
   typedef struct packed {
      ssu_wire_mode_t wire_mode;
      ssu_clk_src_t   clk_src;
   } ssu_ctrl_t;

   // ==================================================================
   // port register and direction bits for the pins
   typedef struct packed {
      logic port_scl;
      logic port_sda;
      logic ddr_scl;
      logic ddr_sda;
      logic ddr_do;
   } ssu_pins_t;

endpackage : ssu_pkg

//--- hw/ssu_two_wire_slave.sv
// serial shift unit with 4-bit edge counter, two-wire slave and three-wire roles
//
// Contract
// R1: two-wire pins: no slew limit, no noise filter; code filters scl and sda until two stages agree
// R2: master makes clock; only slave holds clock
// R3: two-wire shifting clocked on negative scl edge
// R4: master checks scl went high after release
// R5: each serial clock increments the 4-bit counter
// R6: sda falling while scl high sets start flag
// R7: sda low if msb or port zero, direction output
// R8: after start, hold scl low from falling edge
// R9: sample sda into shift register on rising scl
// R10: eight bits overflow counter, scl held low
// R11: unaddressed slave releases scl, awaits start
// R12: addressed slave acks; counter preset to fourteen
// R13: read bit one means slave drives sda
// R14: bytes flow one direction until stop or start
// R15: missing ack ends a transfer
// R16: start detector delays sda before comparing scl
// R17: start detector only in two-wire, own clock
// R18: serial clock at most quarter system clock
// R19: three-wire slave: external edge, data out pin
// R20: external clock counts both edges
// R21: preset fifteen: next edge overflows, edge interrupt
// R22: software strobe or timer match clocks counter
// R23: overflow flag sets on wrap, clears by one
// R24: start flag clears by one, releases hold
// R25: scl and sda synchronised before edge detection
`include "ssu_consts.svh"

module ssu_two_wire_slave (
   input  wire logic              clk_i,          // system clock, 200 MHz
   input  wire logic              nrst_i,         // asynchronous reset, active low
   input  wire logic              link_clk_i,     // free running clock of the start detector
   input  wire ssu_pkg::ssu_ctrl_t ctrl_i,        // wire mode and clock source
   input  wire ssu_pkg::ssu_pins_t pins_i,        // port and direction bits
   input  wire logic              sw_strobe_i,    // software_clock_strobe, one cycle
   input  wire logic              tgl_strobe_i,   // clock_toggle_strobe, one cycle
   input  wire logic              timer_match_i,  // timer compare match, one cycle
   input  wire logic              data_wr_i,      // write of the shift register
   input  wire logic [7:0]        data_i,         // value written to the shift register
   input  wire logic              cnt_wr_i,       // write of the counter
   input  wire logic [3:0]        cnt_i,          // value written to the counter
   input  wire logic              clr_start_i,    // write one to start_detect_flag
   input  wire logic              clr_ovf_i,      // write one to counter_overflow_flag
   input  wire logic              scl_i,          // serial clock pin level
   input  wire logic              sda_i,          // serial data pin level
   input  wire logic              di_i,           // serial_data_in_pin, three-wire
   output logic                   scl_o,          // serial clock pin output value
   output logic                   scl_oe_o,       // serial clock pin pulled low
   output logic                   sda_o,          // serial data pin output value
   output logic                   sda_oe_o,       // serial data pin pulled low
   output logic                   do_o,           // three-wire data out
   output logic                   do_oe_o,        // three-wire data out enable
   output logic [7:0]             shift_o,        // serial_shift_register
   output logic [3:0]             count_o,        // counter value
   output logic                   start_flag_o,   // start_detect_flag
   output logic                   ovf_flag_o      // counter_overflow_flag
);

   // ==================================================================
   // link domain: start detector
   logic [1:0] l_scl;        // scl three-stage synchroniser
   logic       l_scl3;
   logic [1:0] l_sda;        // sda three-stage synchroniser
   logic       l_sda3;
   logic [2:0] l_mode;       // two-wire mode three-stage synchroniser
   logic       l_two;        // filtered two-wire mode
   logic       lscl;         // filtered scl
   logic       lsda;         // filtered sda
   logic       lsda_dly;     // delayed sda
   logic       start_tgl;    // toggles once per start condition
   logic       l_start;

   // pins into the link domain; a change counts when stages two and three agree
   always_ff @(posedge link_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         l_scl  <= 2'h3;
         l_scl3 <= 1'b1;
         l_sda  <= 2'h3;
         l_sda3 <= 1'b1;
         l_mode <= 3'h0;
      end else begin
         l_scl  <= {l_scl[0], scl_i};
         l_scl3 <= l_scl[1];
         l_sda  <= {l_sda[0], sda_i};
         l_sda3 <= l_sda[1];
         l_mode <= {l_mode[1:0], ctrl_i.wire_mode[1]};
      end
   end

   // filtered levels and one link period of sda delay (160 ns)
   always_ff @(posedge link_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         lscl     <= 1'b1;
         lsda     <= 1'b1;
         lsda_dly <= 1'b1;
         l_two    <= 1'b0;
      end else begin
         if (l_mode[1] == l_mode[2]) l_two <= l_mode[2];  // R17
         if (l_scl[1] == l_scl3) lscl <= l_scl3;
         if (l_sda[1] == l_sda3) lsda <= l_sda3;
         lsda_dly <= lsda;  // R16
      end
   end

   // start is sda falling while scl high, compared after the sda delay
   assign l_start = l_two & lscl & lsda_dly & ~lsda;  // R6 R16 R17

   // event leaves the link domain as a toggle
   always_ff @(posedge link_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         start_tgl <= 1'b0;
      end else if (l_start) begin
         start_tgl <= ~start_tgl;  // R17
      end
   end

   // ==================================================================
   // system domain: synchronisers and edge detection
   logic [`SSU_IN_NUM-1:0] raw;
   logic [`SSU_IN_NUM-1:0] s1;
   logic [`SSU_IN_NUM-1:0] s2;
   logic [`SSU_IN_NUM-1:0] s3;
   logic [`SSU_IN_NUM-1:0] filt;
   logic [`SSU_IN_NUM-1:0] filt_d;

   assign raw = {start_tgl, di_i, sda_i, scl_i};

   // scl and sda reset to their idle high level so that no false edge follows reset
   localparam logic [`SSU_IN_NUM-1:0] SYNC_RST = `SSU_SYNC_RST;

   // three flops per input, level accepted once stages two and three agree
   genvar g;
   for (g = 0; g < `SSU_IN_NUM; g++) begin : g_sync
      always_ff @(posedge clk_i or negedge nrst_i) begin
         if (!nrst_i) begin
            s1[g]     <= SYNC_RST[g];
            s2[g]     <= SYNC_RST[g];
            s3[g]     <= SYNC_RST[g];
            filt[g]   <= SYNC_RST[g];
            filt_d[g] <= SYNC_RST[g];
         end else begin
            s1[g]     <= raw[g];
            s2[g]     <= s1[g];
            s3[g]     <= s2[g];
            if (s2[g] == s3[g]) filt[g] <= s3[g];  // R25 R1
            filt_d[g] <= filt[g];
         end
      end
   end

   logic scl_rise;
   logic scl_fall;
   logic start_evt;
   logic two_wire;
   logic ext_clk;

   // edges of the synchronised levels
   assign scl_rise  = filt[`SSU_IN_SCL] & ~filt_d[`SSU_IN_SCL];
   assign scl_fall  = ~filt[`SSU_IN_SCL] & filt_d[`SSU_IN_SCL];
   assign start_evt = filt[`SSU_IN_START] ^ filt_d[`SSU_IN_START];
   assign two_wire  = ctrl_i.wire_mode[1];
   assign ext_clk   = ctrl_i.clk_src[1];

   // ==================================================================
   // clock source selection for counter and shift register
   logic cnt_tick;
   logic shift_tick;
   logic data_bit;

   always_comb begin
      cnt_tick   = 1'b0;
      shift_tick = 1'b0;
      unique case (ctrl_i.clk_src)
         ssu_pkg::SSU_CS_SOFT: begin
            cnt_tick   = sw_strobe_i;  // R22
            shift_tick = sw_strobe_i;
         end
         ssu_pkg::SSU_CS_TIMER: begin
            cnt_tick   = timer_match_i;  // R22
            shift_tick = timer_match_i;
         end
         ssu_pkg::SSU_CS_EXT_POS: begin
            cnt_tick   = scl_rise | scl_fall | (tgl_strobe_i & sw_strobe_i);  // R20 R5
            shift_tick = scl_rise;  // R9 R19
         end
         ssu_pkg::SSU_CS_EXT_NEG: begin
            cnt_tick   = scl_rise | scl_fall | (tgl_strobe_i & sw_strobe_i);  // R20 R5
            shift_tick = scl_fall;  // R3
         end
      endcase
   end

   // two-wire samples sda, other modes the data input pin
   assign data_bit = two_wire ? filt[`SSU_IN_SDA] : filt[`SSU_IN_DI];

   // ==================================================================
   // shift register: a write in the same cycle wins over a shift
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         shift_o <= `SSU_SHIFT_RST;
      end else if (data_wr_i) begin
         shift_o <= data_i;  // R13 R14
      end else if (shift_tick) begin
         shift_o <= {shift_o[6:0], data_bit};  // R9 R3
      end
   end

   // ==================================================================
   // 4-bit counter: preset by software, cleared with the start flag in two-wire modes
   logic cnt_clr;

   assign cnt_clr = two_wire & clr_start_i;

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         count_o <= `SSU_CNT_RST;
      end else if (cnt_wr_i) begin
         count_o <= cnt_i;  // R12 R21
      end else if (cnt_clr) begin
         count_o <= `SSU_CNT_RST;  // R8
      end else if (cnt_tick) begin
         count_o <= count_o + `SSU_CNT_ONE;  // R5
      end
   end

   // ==================================================================
   // flags: a set in the cycle of a clear wins
   logic ovf_set;
   logic start_set;
   logic next_start_flag;

   assign ovf_set   = cnt_tick & ~cnt_wr_i & ~cnt_clr & (count_o == `SSU_CNT_MAX);  // R23 R21 R10
   assign start_set = two_wire ? start_evt : (cnt_tick & ~cnt_wr_i);  // R6
   assign next_start_flag = start_set | (start_flag_o & ~clr_start_i);  // R24

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ovf_flag_o <= 1'b0;
      end else begin
         ovf_flag_o <= ovf_set | (ovf_flag_o & ~clr_ovf_i);  // R23 R22
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         start_flag_o <= 1'b0;
      end else begin
         start_flag_o <= next_start_flag;  // R6 R24
      end
   end

   // ==================================================================
   // clock hold: start hold from the next falling edge, overflow hold
   logic hold_start;
   logic ovf_hold;

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         hold_start <= 1'b0;
      end else begin
         hold_start <= two_wire & next_start_flag & (hold_start | scl_fall);  // R8 R24 R2
      end
   end

   // clearing the overflow flag lets an unaddressed slave go
   assign ovf_hold = (ctrl_i.wire_mode == ssu_pkg::SSU_WM_TWO_OVH) & ovf_flag_o;  // R10 R11 R12

   // ==================================================================
   // pin drivers: open drain, enable high while pulling low
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         scl_o    <= 1'b0;
         sda_o    <= 1'b0;
         scl_oe_o <= 1'b0;
         sda_oe_o <= 1'b0;
      end else begin
         scl_o    <= 1'b0;
         sda_o    <= 1'b0;
         scl_oe_o <= (pins_i.ddr_scl & ~pins_i.port_scl) | hold_start | ovf_hold;  // R2 R8 R10
         sda_oe_o <= two_wire & pins_i.ddr_sda &
                     (~shift_o[`SSU_MSB_POS] | ~pins_i.port_sda);  // R7 R12 R13 R15
      end
   end

   // three-wire data output follows the msb
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         do_o    <= 1'b0;
         do_oe_o <= 1'b0;
      end else begin
         do_o    <= shift_o[`SSU_MSB_POS];  // R19
         do_oe_o <= (ctrl_i.wire_mode == ssu_pkg::SSU_WM_THREE) & pins_i.ddr_do;  // R19
      end
   end

   // ==================================================================
   // assertions
   sequence s_wrap;
      cnt_tick && !cnt_wr_i && !cnt_clr && count_o == 4'hF;
   endsequence

   sequence s_hold_then_pin;
      hold_start ##1 scl_oe_o;
   endsequence

   AST_OVF_SET: assert property (@(posedge clk_i) disable iff (!nrst_i)  // R23
      s_wrap |=> ovf_flag_o && count_o == 4'h0)
      else $error("overflow flag not set on wrap");

   AST_OVF_STICKY: assert property (@(posedge clk_i) disable iff (!nrst_i)  // R23
      ovf_flag_o && !clr_ovf_i |=> ovf_flag_o)
      else $error("overflow flag lost without clear");

   AST_CNT_INC: assert property (@(posedge clk_i) disable iff (!nrst_i)  // R5
      cnt_tick && !cnt_wr_i && !cnt_clr |=> count_o == $past(count_o) + 4'h1)
      else $error("counter did not increment");

   AST_EXT_EDGES: assert property (@(posedge clk_i) disable iff (!nrst_i)  // R20
      ext_clk && (scl_rise || scl_fall) && !cnt_wr_i && !cnt_clr |=> $changed(count_o))
      else $error("external edge not counted");

   AST_START_HOLD: assert property (@(posedge clk_i) disable iff (!nrst_i)  // R8
      two_wire && start_flag_o && scl_fall && !clr_start_i |=> s_hold_then_pin)
      else $error("scl not held after start");

   AST_HOLD_RELEASE: assert property (@(posedge clk_i) disable iff (!nrst_i)  // R24
      hold_start && clr_start_i && !start_set |=> !hold_start && !start_flag_o)
      else $error("start hold not released by clear");

   AST_SDA_PULL: assert property (@(posedge clk_i) disable iff (!nrst_i)  // R7
      two_wire && pins_i.ddr_sda && !shift_o[7] |=> sda_oe_o)
      else $error("sda not pulled low for zero msb");

   AST_SDA_FREE: assert property (@(posedge clk_i) disable iff (!nrst_i)  // R7
      !pins_i.ddr_sda |=> !sda_oe_o)
      else $error("sda driven with direction input");

   AST_SHIFT_IN: assert property (@(posedge clk_i) disable iff (!nrst_i)  // R9
      two_wire && ctrl_i.clk_src == ssu_pkg::SSU_CS_EXT_POS && scl_rise && !data_wr_i
      |=> shift_o == {$past(shift_o[6:0]), $past(filt[1])})
      else $error("sda not shifted in on rising scl");

   AST_OVF_HOLD: assert property (@(posedge clk_i) disable iff (!nrst_i)  // R10
      ctrl_i.wire_mode == ssu_pkg::SSU_WM_TWO_OVH && ovf_flag_o |=> scl_oe_o)
      else $error("scl not held after overflow");

   AST_START_DETECT: assert property (@(posedge link_clk_i) disable iff (!nrst_i)  // R6
      l_start |=> start_tgl != $past(start_tgl))
      else $error("start condition not detected");

   AST_DETECT_OFF: assert property (@(posedge link_clk_i) disable iff (!nrst_i)  // R17
      !l_two |=> $stable(start_tgl))
      else $error("start detector active outside two-wire");

   AST_START_FLAG: assert property (@(posedge clk_i) disable iff (!nrst_i)  // R6
      two_wire && start_evt |=> start_flag_o)
      else $error("start flag not set");

endmodule : ssu_two_wire_slave

//--- test/ssu_master_model.sv
// two-wire bus master model driving scl and sda open drain against a pull-up
module ssu_master_model (
   input  wire logic clk_i,      // system clock, paces the model
   input  wire logic scl_i,      // resolved clock line
   input  wire logic sda_i,      // resolved data line
   output logic      scl_low_o,  // high while pulling scl low
   output logic      sda_low_o   // high while pulling sda low
);
   timeunit 1ns;
   timeprecision 1ps;

   // ==================================================================
   // line control
   initial begin
      scl_low_o = 1'b0;
      sda_low_o = 1'b0;
   end

   // set both pull-downs just after a clock edge
   task automatic drive(input logic s, input logic d);
      @(posedge clk_i);
      scl_low_o <= s;
      sda_low_o <= d;
   endtask : drive

   // half serial period of 20 system cycles, well under a quarter of the clock rate
   task automatic half();
      repeat (20) @(posedge clk_i);
   endtask : half

   // release scl, then wait a bounded time until no slave stretches it
   task automatic free_scl(output logic ok);
      int k;
      ok = 1'b0;
      @(posedge clk_i);
      scl_low_o <= 1'b0;
      for (k = 0; k < 4000 && ok !== 1'b1; k++) begin
         @(posedge clk_i);
         ok = scl_i;
      end
   endtask : free_scl

   // one bit: data set while scl low, clock pulse, sample in the high phase
   task automatic clock_bit(input logic b, output logic got, output logic ok);
      @(posedge clk_i);
      sda_low_o <= ~b;
      half();
      free_scl(ok);
      half();
      got = sda_i;
      @(posedge clk_i);
      scl_low_o <= 1'b1;
      half();
   endtask : clock_bit

   // start: sda falls while scl is high, then scl falls
   task automatic start_cond();
      drive(1'b0, 1'b1);
      repeat (200) @(posedge clk_i);
      drive(1'b1, 1'b1);
      half();
   endtask : start_cond

   // stop: sda rises while scl is high
   task automatic stop_cond(output logic ok);
      drive(1'b1, 1'b1);
      half();
      free_scl(ok);
      half();
      drive(1'b0, 1'b0);
      half();
   endtask : stop_cond
endmodule : ssu_master_model

//--- test/ssu_two_wire_slave_tb.sv
// self-checking bench of the serial shift unit: counter, three-wire and two-wire slave roles
module ssu_two_wire_slave_tb;
   timeunit 1ns;
   timeprecision 1ps;

   // ==================================================================
   // signals
   logic               clk_i, nrst_i, link_clk_i;
   ssu_pkg::ssu_ctrl_t ctrl;
   ssu_pkg::ssu_pins_t pins;
   logic               sw_strobe, tgl_strobe, timer_match, data_wr, cnt_wr, clr_start, clr_ovf, di;
   logic [7:0]         data, shift, tx, rx;
   logic [3:0]         cnt, count, p;
   logic               scl_o, scl_oe, sda_o, sda_oe, do_v, do_oe, start_flag, ovf_flag;
   logic               m_scl_low, m_sda_low, got, ok;
   wire                scl_line;
   wire                sda_line;
   int                 error_cnt, samples_checked, cycles, i, n, b;
   integer             seed;

   // pull-up on both lines, any party may pull low
   assign scl_line = ~((scl_oe & ~scl_o) | m_scl_low);
   assign sda_line = ~((sda_oe & ~sda_o) | m_sda_low);

   ssu_two_wire_slave dut (.clk_i(clk_i), .nrst_i(nrst_i), .link_clk_i(link_clk_i), .ctrl_i(ctrl),
      .pins_i(pins), .sw_strobe_i(sw_strobe), .tgl_strobe_i(tgl_strobe), .timer_match_i(timer_match),
      .data_wr_i(data_wr), .data_i(data), .cnt_wr_i(cnt_wr), .cnt_i(cnt), .clr_start_i(clr_start),
      .clr_ovf_i(clr_ovf), .scl_i(scl_line), .sda_i(sda_line), .di_i(di), .scl_o(scl_o),
      .scl_oe_o(scl_oe), .sda_o(sda_o), .sda_oe_o(sda_oe), .do_o(do_v), .do_oe_o(do_oe),
      .shift_o(shift), .count_o(count), .start_flag_o(start_flag), .ovf_flag_o(ovf_flag));

   ssu_master_model u_master (.clk_i(clk_i), .scl_i(scl_line), .sda_i(sda_line),
      .scl_low_o(m_scl_low), .sda_low_o(m_sda_low));

   // ==================================================================
   // clocks and timeout
   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end
   initial begin
      link_clk_i = 1'b0;
      #37;
      forever #80 link_clk_i = ~link_clk_i;
   end
   always @(posedge clk_i) begin
      cycles++;
      if (cycles > 20000) begin
         error_cnt++;
         report_and_stop();
      end
   end

   // ==================================================================
   // helpers
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic report_and_stop();
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : report_and_stop

   task automatic cyc(input int k);
      repeat (k) @(posedge clk_i);
   endtask : cyc

   // counter write together with clearing both flags
   task automatic preset(input logic [3:0] v);
      @(posedge clk_i);
      {cnt_wr, cnt, clr_start, clr_ovf} <= {1'b1, v, 2'b11};
      @(posedge clk_i);
      {cnt_wr, clr_start, clr_ovf} <= 3'b000;
   endtask : preset

   task automatic clear(input logic s, input logic o);
      @(posedge clk_i);
      {clr_start, clr_ovf} <= {s, o};
      @(posedge clk_i);
      {clr_start, clr_ovf} <= 2'b00;
   endtask : clear

   task automatic wr_data(input logic [7:0] v);
      @(posedge clk_i);
      {data_wr, data} <= {1'b1, v};
      @(posedge clk_i);
      data_wr <= 1'b0;
   endtask : wr_data

   function automatic logic [7:0] exp_cnt(input logic [3:0] p0, input int k);
      return {4'h0, p0 + k[3:0]};
   endfunction : exp_cnt

   function automatic logic [7:0] exp_ovf(input logic [3:0] p0, input int k);
      return {7'h00, (5'(p0) + k[4:0]) > 5'h0F};
   endfunction : exp_ovf

   // ==================================================================
   // main sequence
   initial begin
      seed = 32'h0951C622;
      nrst_i = 1'b0;
      ctrl = '{ssu_pkg::SSU_WM_OFF, ssu_pkg::SSU_CS_SOFT};
      pins = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
      {sw_strobe, tgl_strobe, timer_match, data_wr, cnt_wr, clr_start, clr_ovf, di} = 8'h00;
      data = 8'h00;
      cnt = 4'h0;
      repeat (10) @(posedge clk_i);
      repeat (2) @(posedge link_clk_i);
      @(posedge clk_i);
      nrst_i <= 1'b1;
      cyc(10);
      check({count, start_flag, ovf_flag, scl_oe, sda_oe}, 8'h00);
      check({7'h00, do_oe}, 8'h00);
      check(shift, 8'h00);
      // software strobe and timer match counting, corner presets first
      for (i = 0; i < 24; i++) begin
         p = 4'($random(seed));
         n = 1 + ($unsigned($random(seed)) % 8);
         if (i < 2) begin
            p = 4'hF;
            n = i ? 8 : 1;
         end
         ctrl.clk_src <= i[0] ? ssu_pkg::SSU_CS_TIMER : ssu_pkg::SSU_CS_SOFT;
         preset(p);
         repeat (n) begin
            @(posedge clk_i);
            {sw_strobe, timer_match} <= {~i[0], i[0]};
         end
         @(posedge clk_i);
         {sw_strobe, timer_match} <= 2'b00;
         cyc(2);
         check({4'h0, count}, exp_cnt(p, n));
         check({7'h00, ovf_flag}, exp_ovf(p, n));
         check({7'h00, start_flag}, 8'h01);
      end
      clear(1'b0, 1'b1);
      cyc(2);
      check({7'h00, ovf_flag}, 8'h00);
      // external clock counts both edges; preset fifteen overflows on one edge
      ctrl.clk_src <= ssu_pkg::SSU_CS_EXT_POS;
      preset(4'hF);
      u_master.drive(1'b1, 1'b0);
      cyc(8);
      check({count, 3'h0, ovf_flag}, 8'h01);
      u_master.drive(1'b0, 1'b0);
      cyc(8);
      check({4'h0, count}, 8'h01);
      @(posedge clk_i);
      {sw_strobe, tgl_strobe} <= 2'b11;
      @(posedge clk_i);
      {sw_strobe, tgl_strobe} <= 2'b00;
      cyc(2);
      check({4'h0, count}, 8'h02);
      // three-wire slave byte exchange
      tx = 8'($random(seed));
      rx = 8'($random(seed));
      ctrl.wire_mode <= ssu_pkg::SSU_WM_THREE;
      pins.ddr_do <= 1'b1;
      u_master.drive(1'b1, 1'b0);
      cyc(8);
      wr_data(tx);
      preset(4'h0);
      cyc(3);
      check({6'h00, do_v, do_oe}, {6'h00, tx[7], 1'b1});
      for (b = 7; b >= 0; b--) begin
         @(posedge clk_i);
         di <= rx[b];
         cyc(20);
         u_master.drive(1'b0, 1'b0);
         cyc(20);
         u_master.drive(1'b1, 1'b0);
         cyc(20);
      end
      check(shift, rx);
      check({count, 3'h0, ovf_flag}, 8'h01);
      // two-wire sda pull-down from msb or port bit
      ctrl <= '{ssu_pkg::SSU_WM_TWO, ssu_pkg::SSU_CS_SOFT};
      pins.ddr_sda <= 1'b1;
      preset(4'h0);
      for (i = 0; i < 4; i++) begin
         @(posedge clk_i);
         pins.port_sda <= i[0];
         wr_data({i[1], 7'h00});
         cyc(3);
         check({7'h00, sda_oe}, {7'h00, ~(i[1] & i[0])});
      end
      @(posedge clk_i);
      pins.ddr_sda <= 1'b0;
      cyc(3);
      check({7'h00, sda_oe}, 8'h00);
      u_master.drive(1'b0, 1'b0);
      // two-wire slave: start, hold, address byte, acknowledge
      tx = 8'($random(seed));
      ctrl <= '{ssu_pkg::SSU_WM_TWO_OVH, ssu_pkg::SSU_CS_EXT_POS};
      preset(4'h0);
      cyc(5);
      u_master.start_cond();
      cyc(20);
      check({7'h00, start_flag}, 8'h01);
      check({7'h00, scl_oe}, 8'h01);
      u_master.drive(1'b0, 1'b1);
      cyc(20);
      check({7'h00, scl_line}, 8'h00);
      u_master.drive(1'b1, 1'b1);
      clear(1'b1, 1'b0);
      cyc(3);
      check({count, start_flag, 2'b00, scl_oe}, 8'h00);
      for (b = 7; b >= 0; b--) begin
         u_master.clock_bit(tx[b], got, ok);
         check({7'h00, ok}, 8'h01);
      end
      cyc(8);
      check(shift, tx);
      check({count, 3'h0, ovf_flag}, 8'h01);
      check({7'h00, scl_oe}, 8'h01);
      @(posedge clk_i);
      pins.ddr_sda <= 1'b1;
      wr_data(8'h00);
      preset(4'hE);
      cyc(3);
      u_master.clock_bit(1'b1, got, ok);
      check({6'h00, got, ok}, 8'h01);
      cyc(8);
      check({count, ovf_flag, 2'b00, scl_oe}, 8'h09);
      @(posedge clk_i);
      pins.ddr_sda <= 1'b0;
      clear(1'b0, 1'b1);
      cyc(3);
      check({6'h00, scl_oe, sda_oe}, 8'h00);
      u_master.stop_cond(ok);
      cyc(20);
      check({6'h00, start_flag, ok}, 8'h01);
      report_and_stop();
   end
endmodule : ssu_two_wire_slave_tb
